//--- cfg_consts.svh
`ifndef CFG_CONSTS_SVH
`define CFG_CONSTS_SVH

// ----------------------------------------
// Reset values and defaults
// ----------------------------------------
`define CFG_NUM_OUTPUTS     10
`define CFG_RST_SYNC        3'h0
`define CFG_RST_LEVEL       1'h0
`define CFG_RST_OE_N        1'h1
`define CFG_RESUME_MAX_CYC  2

`endif

//--- cfg_pkg.sv
package cfg_pkg;

  // ----------------------------------------
  // Gating states
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    CFG_ST_HIZ   = 3'h1,
    CFG_ST_LOW   = 3'h2,
    CFG_ST_DRIVE = 3'h4
  } cfg_state_t;

  // ----------------------------------------
  // Whole module state
  // ----------------------------------------
  typedef struct packed
  {
    logic [2:0]  ref_sync_ff;
    logic        ref_lvl_ff;
    logic [2:0]  en_sync_ff;
    logic        en_lvl_ff;
    cfg_state_t  state_ff;
    logic        out_lvl_ff;
    logic        out_oe_n_ff;
  } cfg_regs_t;

endpackage

//--- cfg_clock_fanout_output_gate.sv
`timescale 1ns/1ns
// Notes on behaviour
// R1 - A falling enable keeps outputs driven until the next falling input edge, then floats them.
// R2 - Outputs stay floating for as long as the enable stays low.
// R3 - Raising the enable while floating drives all outputs low at once, with no input edge.
// R4 - Toggling resumes only after a falling input edge and within two input cycles of the raise.
// R5 - With the input static, a rising enable still forces the floating outputs low.
// R6 - With the input static, a later falling enable does not float the outputs until a falling edge.
// R7 - Every enable change reaches all outputs on the same edge, so no runt pulse or glitch appears.

`include "cfg_consts.svh"

module cfg_clock_fanout_output_gate
  import cfg_pkg::*;
#(
  parameter int NUM_OUTPUTS = `CFG_NUM_OUTPUTS
)
(
  input  wire logic                   mclk_i,
  input  wire logic                   resetn_i,
  input  wire logic                   ref_clk_i,
  input  wire logic                   out_enable_i,
  output logic [NUM_OUTPUTS-1:0]      clk_out_o,
  output logic [NUM_OUTPUTS-1:0]      clk_out_oe_n_o
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (NUM_OUTPUTS < 1)
  begin : g_bad_param
    $error("NUM_OUTPUTS must be at least 1");
  end

  // ----------------------------------------
  // Reset image of the register set
  // ----------------------------------------
  localparam cfg_regs_t RST_REGS =
  '{
    ref_sync_ff : `CFG_RST_SYNC,
    ref_lvl_ff  : `CFG_RST_LEVEL,
    en_sync_ff  : `CFG_RST_SYNC,
    en_lvl_ff   : `CFG_RST_LEVEL,
    state_ff    : CFG_ST_HIZ,
    out_lvl_ff  : `CFG_RST_LEVEL,
    out_oe_n_ff : `CFG_RST_OE_N
  };

  // ----------------------------------------
  // Register set and edge flag
  // ----------------------------------------
  cfg_regs_t regs_ff;
  cfg_regs_t nxt_regs;
  logic      ref_fall;

  // ----------------------------------------
  // Three-stage chain on an asynchronous pin
  // ----------------------------------------
  function automatic logic [2:0] cfg_shift
  (
    input logic [2:0] chain,
    input logic       pin
  );
    return {chain[1:0], pin};
  endfunction

  // ----------------------------------------
  // Level filter behind a chain
  // ----------------------------------------
  function automatic logic cfg_filter
  (
    input logic [2:0] sync,
    input logic       level
  );
    logic result;
    result = level;
    // A change counts once the second and third stages agree
    if (sync[1] == sync[2])
    begin
      result = sync[2];
    end
    return result;
  endfunction

  // ----------------------------------------
  // Falling edge of a filtered level
  // ----------------------------------------
  function automatic logic cfg_fell
  (
    input logic old_level,
    input logic new_level
  );
    return old_level & ~new_level;
  endfunction

  // ----------------------------------------
  // Gating state machine
  // ----------------------------------------
  function automatic cfg_state_t cfg_next_state
  (
    input cfg_state_t state,
    input logic       en_level,
    input logic       ref_edge
  );
    cfg_state_t result;
    result = state;
    case (state)
      CFG_ST_DRIVE:
      begin
        // Keep driving until a falling input edge with the enable low
        if (!en_level && ref_edge)
        begin
          result = CFG_ST_HIZ; // [R1]
        end
      end
      CFG_ST_HIZ:
      begin
        // Floating for as long as the enable is seen low
        if (en_level) // [R2]
        begin
          result = CFG_ST_LOW; // [R3] [R5]
        end
      end
      CFG_ST_LOW:
      begin
        // Held low until a falling edge, then toggle or float
        if (ref_edge && en_level)
        begin
          result = CFG_ST_DRIVE; // [R4]
        end
        else if (ref_edge)
        begin
          result = CFG_ST_HIZ; // [R6]
        end
      end
      default:
      begin
        // Illegal codes fall back to floating
        result = CFG_ST_HIZ;
      end
    endcase
    return result;
  endfunction

  // ----------------------------------------
  // Pin state for a gating state
  // ----------------------------------------
  function automatic logic cfg_pin_oe_n
  (
    input cfg_state_t state
  );
    logic result;
    result = 1'h0;
    if (state == CFG_ST_HIZ)
    begin
      result = 1'h1;
    end
    return result;
  endfunction

  function automatic logic cfg_pin_level
  (
    input cfg_state_t state,
    input logic       ref_level
  );
    logic result;
    result = 1'h0;
    // Only the toggling state lets the input through
    if (state == CFG_ST_DRIVE)
    begin
      result = ref_level;
    end
    return result;
  endfunction

  function automatic logic [NUM_OUTPUTS-1:0] cfg_fan
  (
    input logic level
  );
    return {NUM_OUTPUTS{level}};
  endfunction

  // ----------------------------------------
  // Next register set
  // ----------------------------------------
  always_comb
  begin
    nxt_regs = regs_ff;
    nxt_regs.ref_sync_ff = cfg_shift(regs_ff.ref_sync_ff, ref_clk_i);
    nxt_regs.en_sync_ff  = cfg_shift(regs_ff.en_sync_ff, out_enable_i);
    nxt_regs.ref_lvl_ff  = cfg_filter(regs_ff.ref_sync_ff, regs_ff.ref_lvl_ff);
    nxt_regs.en_lvl_ff   = cfg_filter(regs_ff.en_sync_ff, regs_ff.en_lvl_ff);
    // Edge judged on the filtered level, never on the raw pin
    ref_fall             = cfg_fell(regs_ff.ref_lvl_ff, nxt_regs.ref_lvl_ff);
    nxt_regs.state_ff    = cfg_next_state(regs_ff.state_ff, nxt_regs.en_lvl_ff, ref_fall);
    // One shared level and enable for every pin, changed on one edge
    nxt_regs.out_oe_n_ff = cfg_pin_oe_n(nxt_regs.state_ff); // [R2] [R7]
    nxt_regs.out_lvl_ff  = cfg_pin_level(nxt_regs.state_ff, nxt_regs.ref_lvl_ff); // [R7]
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      regs_ff <= RST_REGS;
    end
    else
    begin
      regs_ff <= nxt_regs;
    end
  end

  // ----------------------------------------
  // Fanout of the registered pin state
  // ----------------------------------------
  assign clk_out_o      = cfg_fan(regs_ff.out_lvl_ff); // [R7]
  assign clk_out_oe_n_o = cfg_fan(regs_ff.out_oe_n_ff); // [R7]

endmodule

//--- cfg_gate_props.sv
`timescale 1ns/1ns
// --
// Gating checks
// --
module cfg_gate_props #(parameter int NUM_OUTPUTS = 10)
(
  input wire logic                   mclk_i,
  input wire logic                   resetn_i,
  input wire logic                   ref_clk_i,
  input wire logic                   out_enable_i,
  input wire logic [NUM_OUTPUTS-1:0] clk_out_o,
  input wire logic [NUM_OUTPUTS-1:0] clk_out_oe_n_o
);
  wire z = &clk_out_oe_n_o;
  wire d = ~|clk_out_oe_n_o;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  AST_HOLD: assert property (d && ref_clk_i |=> d) else $error("early float");
  AST_FLT: assert property (
    $rose(z) |-> !ref_clk_i && $past(ref_clk_i, 5) && clk_out_o == '0)
    else $error("float off edge");
  AST_STAY: assert property ((!out_enable_i)[*5] ##0 z |=> z) else $error("left float");
  AST_WAKE: assert property (
    $rose(out_enable_i) && z |-> ##[1:8] (d && clk_out_o == '0))
    else $error("no wake low");
  AST_EN: assert property (out_enable_i[*6] |-> !z) else $error("still float");
  AST_RES: assert property ($rose(clk_out_o[0]) |-> d && ref_clk_i) else $error("bad rise");
  AST_ALL: assert property (
    (clk_out_o == '0 || &clk_out_o) && (z || d) && (!z || clk_out_o == '0))
    else $error("skew");
  cover property ($rose(z));
  cover property ($fell(z) ##[1:40] $rose(clk_out_o[0]));
  cover property ($fell(z));
  cover property ($rose(clk_out_o[0]));
endmodule
bind cfg_clock_fanout_output_gate cfg_gate_props #(.NUM_OUTPUTS(NUM_OUTPUTS)) u_props
  (.mclk_i(mclk_i), .resetn_i(resetn_i), .ref_clk_i(ref_clk_i), .out_enable_i(out_enable_i),
  .clk_out_o(clk_out_o), .clk_out_oe_n_o(clk_out_oe_n_o));

//--- cfg_ref_src.sv
`timescale 1ns/1ns
// --
// Reference source, period 10 mclk, frozen while run_i is low
// --
module cfg_ref_src
(
  input  wire logic mclk_i,
  input  wire logic run_i,
  output logic      ref_clk_o = 1'h1
);
  logic [2:0] cnt = 3'h0;
  always @(posedge mclk_i)
    if (run_i)
    begin
      cnt <= (cnt == 3'h4) ? 3'h0 : cnt + 3'h1;
      ref_clk_o <= (cnt == 3'h4) ? ~ref_clk_o : ref_clk_o;
    end
endmodule

//--- tb_clock_fanout_output_gate.sv
`timescale 1ns/1ns
// --
// Enable gating scenarios
// --
module tb_clock_fanout_output_gate;
  logic       clk = 1'h0;
  logic       rst_n = 1'h0;
  logic       en = 1'h0;
  logic       run = 1'h1;
  logic       rc;
  logic [9:0] out;
  logic [9:0] oe_n;
  int         failures = 0;
  int         tests_run = 0;
  cfg_ref_src src (.mclk_i(clk), .run_i(run), .ref_clk_o(rc));
  cfg_clock_fanout_output_gate dut (.mclk_i(clk), .resetn_i(rst_n), .ref_clk_i(rc),
    .out_enable_i(en), .clk_out_o(out), .clk_out_oe_n_o(oe_n));
  initial forever #50 clk = ~clk;
  task chk(input logic [9:0] e, input logic [9:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task wt(input bit o, input logic [9:0] e, input int n);
    for (int i = 0; i < n && (o ? out : oe_n) !== e; i++)
      @(posedge clk) #1;
    chk(e, o ? out : oe_n);
  endtask
  task t_run;
    @(posedge clk) en <= 1'h1;
    wt(1, 10'h3FF, 30);
    chk(10'h000, oe_n);
    wt(1, 10'h000, 10);
    @(posedge clk) en <= 1'h0;
    wt(1, 10'h3FF, 10);
    chk(10'h000, oe_n);
    wt(0, 10'h3FF, 20);
    chk(10'h000, out);
    repeat (30) @(posedge clk);
    #1 chk(10'h3FF, oe_n);
  endtask
  task t_static;
    @(posedge clk) run <= 1'h0;
    repeat (4) @(posedge clk);
    en <= 1'h1;
    wt(0, 10'h000, 8);
    chk(10'h000, out);
    @(posedge clk) en <= 1'h0;
    repeat (20) @(posedge clk);
    #1 chk(10'h000, oe_n);
    chk(10'h000, out);
    @(posedge clk) run <= 1'h1;
    wt(0, 10'h3FF, 30);
  endtask
  task results;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    t_run();
    t_static();
    results();
  end
  initial
  begin
    #200000;
    failures++;
    results();
  end
endmodule
